// ===== src/asw_pkg.sv
package asw_pkg;

  // ==========================================================================
  // Register map (byte addresses, word aligned except sweep control at 0x3D7)
  localparam logic [11:0] ASW_MODE_OFS      = 12'h3D4;
  localparam logic [11:0] ASW_SWEEP_OFS     = 12'h3D7;
  localparam logic [11:0] ASW_EXTRA_OFS     = 12'h3D8;
  // Result window kept clear of the control registers at 0x3D4..0x3D8
  localparam logic [11:0] ASW_RESULT_OFS    = 12'h3A0;
  localparam logic [7:0]  ASW_SWEEP_RST     = 8'h00;
  localparam logic [7:0]  ASW_MODE_RST      = 8'h00;
  localparam logic [7:0]  ASW_EXTRA_RST     = 8'h00;

  // ==========================================================================
  // Field positions, mode control
  localparam int ASW_CH_LSB    = 0;
  localparam int ASW_MD_LSB    = 3;
  localparam int ASW_TRG_BIT   = 5;
  localparam int ASW_START_BIT = 6;
  // Field positions, sweep control
  localparam int ASW_SCAN_LSB  = 0;
  localparam int ASW_MDX_BIT   = 2;
  localparam int ASW_BITS_BIT  = 3;
  localparam int ASW_REFERENCE_CONNECT_BIT  = 5;
  // Field positions, extra control
  localparam int ASW_GSEL_LSB  = 1;

  localparam logic [1:0] ASW_MD_SINGLE_SWEEP = 2'h2;
  localparam logic [1:0] ASW_MD_REPEAT_SWEEP = 2'h3;

  // ==========================================================================
  // Timing
  localparam int ASW_CLK_MHZ       = 125;
  localparam int ASW_VREF_SETTLE_NS = 1000;
  localparam int ASW_VREF_SETTLE_CYC = (ASW_VREF_SETTLE_NS * ASW_CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [31:0] writedata;
  } asw_avs_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } asw_avs_rsp_t;

  typedef struct packed {
    logic       req;
    logic [2:0] channel;
    logic [1:0] group;
    logic       ten_bit;
  } asw_conv_req_t;

  typedef struct packed {
    logic       done;
    logic [9:0] data;
  } asw_conv_rsp_t;

endpackage

// ===== src/asw_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module asw_ctrl
  import asw_pkg::*;
#(
  parameter int NUM_CH = 8
)(
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire asw_pkg::asw_avs_req_t  avs_req,
  output var  asw_pkg::asw_avs_rsp_t  avs_rsp,
  input  wire logic                   external_trigger_input,
  output var  asw_pkg::asw_conv_req_t conv_req,
  input  wire asw_pkg::asw_conv_rsp_t conv_rsp,
  output logic                        conv_done_irq,
  output logic                        reference_connect
);
  import asw_pkg::*;

  // Two-bit pin select field covers eight channels at most
  if (NUM_CH != 8)
  begin : g_bad_num_ch
    $error("asw_ctrl serves exactly eight channels");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV, ST_WAIT} asw_state_t;

  typedef struct packed {
    logic [7:0]       mode_ctl;
    logic [7:0]       sweep_ctl;
    logic [7:0]       extra_ctl;
    asw_state_t       st;
    logic [2:0]       ch;
    logic [2:0]       trg_sync;
    logic             trg_last;
    logic [NUM_CH-1:0][9:0] result;
    logic             irq;
    logic             ack;
    logic [31:0]      rdata;
  } asw_regs_t;

  asw_regs_t s_r;
  asw_regs_t s_nxt;

  // ==========================================================================
  // Decode helpers
  function automatic logic [2:0] last_ch(input logic [1:0] scan);
    last_ch = {scan, 1'b1};
  endfunction

  function automatic logic is_repeat0(input logic [7:0] m, input logic [7:0] s);
    is_repeat0 = (m[ASW_MD_LSB +: 2] == ASW_MD_REPEAT_SWEEP) && !s[ASW_MDX_BIT];
  endfunction

  logic trg_fall;
  logic rep0;
  logic acc;
  logic [31:0] wd;

  always_comb
  begin
    s_nxt    = s_r;
    wd       = avs_req.writedata;
    rep0     = is_repeat0(s_r.mode_ctl, s_r.sweep_ctl);
    // Sync taps 2 and 3 agree on a change before it counts
    s_nxt.trg_sync = {s_r.trg_sync[1:0], external_trigger_input};
    if (s_r.trg_sync[2] == s_r.trg_sync[1])
      s_nxt.trg_last = s_r.trg_sync[2];
    trg_fall = s_r.trg_last && (s_r.trg_sync[2] == s_r.trg_sync[1]) && !s_r.trg_sync[2];
    s_nxt.irq = 1'b0;
    s_nxt.ack = 1'b0;
    acc = (avs_req.read || avs_req.write) && !s_r.ack;

    // ========================================================================
    // Conversion sequencer
    unique case (s_r.st)
      ST_IDLE:
      begin
        if (s_r.mode_ctl[ASW_START_BIT])
        begin
          s_nxt.ch = 3'h0;
          s_nxt.st = s_r.mode_ctl[ASW_TRG_BIT] ? ST_ARMED : ST_CONV;
        end
      end
      ST_ARMED:
      begin
        if (trg_fall)
          s_nxt.st = ST_CONV;
      end
      ST_CONV:
        s_nxt.st = ST_WAIT;
      ST_WAIT:
      begin
        if (conv_rsp.done)
        begin
          // 8-bit results keep the low byte only
          s_nxt.result[s_r.ch] = s_r.sweep_ctl[ASW_BITS_BIT] ? conv_rsp.data
                                 : {2'b00, conv_rsp.data[7:0]};
          if (s_r.ch != last_ch(s_r.sweep_ctl[ASW_SCAN_LSB +: 2]))
          begin
            s_nxt.ch = s_r.ch + 3'h1;
            s_nxt.st = ST_CONV;
          end
          else if (rep0)
          begin
            s_nxt.ch = 3'h0;
            s_nxt.st = ST_CONV;
          end
          else
          begin
            s_nxt.st = ST_IDLE;
            s_nxt.mode_ctl[ASW_START_BIT] = 1'b0;
            s_nxt.irq = 1'b1;
          end
        end
      end
    endcase
    // Stop request from software wins over the next state; a result arriving with done is still stored
    if (!s_r.mode_ctl[ASW_START_BIT] && s_r.st != ST_IDLE)
      s_nxt.st = ST_IDLE;

    // ========================================================================
    // Avalon slave, one wait cycle per access
    if (acc)
    begin
      s_nxt.ack   = 1'b1;
      s_nxt.rdata = 32'h0000_0000;
      if (avs_req.write)
      begin
        if (avs_req.address == ASW_MODE_OFS)
          s_nxt.mode_ctl = wd[7:0];
        else if (avs_req.address == ASW_SWEEP_OFS)
          s_nxt.sweep_ctl = wd[7:0];
        else if (avs_req.address == ASW_EXTRA_OFS)
          s_nxt.extra_ctl = wd[7:0];
      end
      else
      begin
        if (avs_req.address == ASW_MODE_OFS)
          s_nxt.rdata = {24'h000000, s_r.mode_ctl};
        else if (avs_req.address == ASW_SWEEP_OFS)
          s_nxt.rdata = {24'h000000, s_r.sweep_ctl};
        else if (avs_req.address == ASW_EXTRA_OFS)
          s_nxt.rdata = {24'h000000, s_r.extra_ctl};
        else if (avs_req.address[11:5] == ASW_RESULT_OFS[11:5] && avs_req.address[1:0] == 2'b00)
          s_nxt.rdata = {22'h0, s_r.result[avs_req.address[4:2]]};
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      s_r           <= '0;
      s_r.mode_ctl  <= ASW_MODE_RST;
      s_r.sweep_ctl <= ASW_SWEEP_RST;
      s_r.extra_ctl <= ASW_EXTRA_RST;
      s_r.st        <= ST_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================================
  // Outputs; the single-channel field is never used by sweeps
  always_comb
  begin
    avs_rsp.waitrequest = !s_r.ack;
    avs_rsp.readdata    = s_r.rdata;
    conv_req.req        = (s_r.st == ST_CONV);
    conv_req.channel    = s_r.ch;
    conv_req.group      = s_r.extra_ctl[ASW_GSEL_LSB +: 2];
    conv_req.ten_bit    = s_r.sweep_ctl[ASW_BITS_BIT];
  end
  assign conv_done_irq       = s_r.irq;
  assign reference_connect   = s_r.sweep_ctl[ASW_REFERENCE_CONNECT_BIT];

  // ==========================================================================
  // Checks
  property p_no_irq_rep0;
    @(posedge sys_clk) disable iff (!rstn)
      is_repeat0(s_r.mode_ctl, s_r.sweep_ctl) |=> !conv_done_irq;
  endproperty
  a_no_irq_rep0: assert property (p_no_irq_rep0) else $error("irq in repeat sweep");

  property p_soft_start;
    @(posedge sys_clk) disable iff (!rstn)
      (s_r.st == ST_IDLE && s_r.mode_ctl[ASW_START_BIT] && !s_r.mode_ctl[ASW_TRG_BIT]) |=> conv_req.req;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("soft start late");

  property p_armed_holds;
    @(posedge sys_clk) disable iff (!rstn)
      (s_r.st == ST_ARMED && !trg_fall && s_r.mode_ctl[ASW_START_BIT]) |=> !conv_req.req;
  endproperty
  a_armed_holds: assert property (p_armed_holds) else $error("start without edge");

  property p_stop;
    @(posedge sys_clk) disable iff (!rstn)
      !s_r.mode_ctl[ASW_START_BIT] |=> s_r.st == ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop on clear");

  property p_wrap;
    @(posedge sys_clk) disable iff (!rstn)
      (s_r.st == ST_WAIT && conv_rsp.done && rep0 && s_r.mode_ctl[ASW_START_BIT]
       && s_r.ch == last_ch(s_r.sweep_ctl[1:0])) |=> (conv_req.req && conv_req.channel == 3'h0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("repeat wrap wrong");

  property p_range;
    @(posedge sys_clk) disable iff (!rstn)
      conv_req.req |-> conv_req.channel <= last_ch(s_r.sweep_ctl[1:0]);
  endproperty
  a_range: assert property (p_range) else $error("channel beyond set");

  property p_res8;
    @(posedge sys_clk) disable iff (!rstn)
      (s_r.st == ST_WAIT && conv_rsp.done && !s_r.sweep_ctl[ASW_BITS_BIT] && s_r.mode_ctl[ASW_START_BIT])
      |=> s_r.result[$past(s_r.ch)][9:8] == 2'b00;
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit result wide");

  property p_single_end;
    @(posedge sys_clk) disable iff (!rstn)
      conv_done_irq |-> !s_r.mode_ctl[ASW_START_BIT];
  endproperty
  a_single_end: assert property (p_single_end) else $error("flag still set");

  // ==========================================================================
  // Bus checks: one wait state, answer stands one cycle
  // Writes land on the taking edge, the same edge that raises the answer
  property p_bus_answer;
    @(posedge sys_clk) disable iff (!rstn)
      ((avs_req.read || avs_req.write) && avs_rsp.waitrequest) |=> !avs_rsp.waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  property p_answer_once;
    @(posedge sys_clk) disable iff (!rstn)
      !avs_rsp.waitrequest |=> avs_rsp.waitrequest;
  endproperty
  a_answer_once: assert property (p_answer_once) else $error("bus answer repeated");

  property p_sweep_write;
    @(posedge sys_clk) disable iff (!rstn)
      (avs_req.write && avs_rsp.waitrequest && avs_req.address == ASW_SWEEP_OFS)
      |=> s_r.sweep_ctl == $past(avs_req.writedata[7:0]);
  endproperty
  a_sweep_write: assert property (p_sweep_write) else $error("sweep write lost");

  // ==========================================================================
  // Sequencer checks
  property p_req_pulse;
    @(posedge sys_clk) disable iff (!rstn)
      conv_req.req |=> !conv_req.req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request held");

  property p_irq_pulse;
    @(posedge sys_clk) disable iff (!rstn)
      conv_done_irq |=> !conv_done_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq held");

  property p_idle_armed;
    @(posedge sys_clk) disable iff (!rstn)
      (s_r.st == ST_IDLE && s_r.mode_ctl[ASW_START_BIT] && s_r.mode_ctl[ASW_TRG_BIT])
      |=> (s_r.st == ST_ARMED && !conv_req.req);
  endproperty
  a_idle_armed: assert property (p_idle_armed) else $error("external start not armed");

  property p_armed_go;
    @(posedge sys_clk) disable iff (!rstn)
      (s_r.st == ST_ARMED && trg_fall && s_r.mode_ctl[ASW_START_BIT]) |=> conv_req.req;
  endproperty
  a_armed_go: assert property (p_armed_go) else $error("edge did not start");

  // A falling edge counts once, however long the pin stays low
  property p_trg_once;
    @(posedge sys_clk) disable iff (!rstn)
      trg_fall |=> !trg_fall;
  endproperty
  a_trg_once: assert property (p_trg_once) else $error("edge counted twice");

  // A clear that lands with a done still lets one request out
  property p_stop_no_req;
    @(posedge sys_clk) disable iff (!rstn)
      (!s_r.mode_ctl[ASW_START_BIT] && s_r.st != ST_CONV) |=> !conv_req.req;
  endproperty
  a_stop_no_req: assert property (p_stop_no_req) else $error("request after stop");

  property p_step;
    @(posedge sys_clk) disable iff (!rstn)
      (s_r.st == ST_WAIT && conv_rsp.done && s_r.mode_ctl[ASW_START_BIT]
       && s_r.ch != last_ch(s_r.sweep_ctl[ASW_SCAN_LSB +: 2]))
      |=> (conv_req.req && conv_req.channel == $past(s_r.ch) + 3'h1);
  endproperty
  a_step: assert property (p_step) else $error("channel step wrong");

  property p_single_stop;
    @(posedge sys_clk) disable iff (!rstn)
      (s_r.st == ST_WAIT && conv_rsp.done && !rep0 && s_r.mode_ctl[ASW_START_BIT]
       && s_r.ch == last_ch(s_r.sweep_ctl[ASW_SCAN_LSB +: 2])) |=> (s_r.st == ST_IDLE && conv_done_irq);
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single sweep did not end");

  property p_rep0_runs;
    @(posedge sys_clk) disable iff (!rstn)
      (s_r.st == ST_WAIT && conv_rsp.done && rep0 && s_r.mode_ctl[ASW_START_BIT]) |=> s_r.st == ST_CONV;
  endproperty
  a_rep0_runs: assert property (p_rep0_runs) else $error("repeat sweep halted");

  // Results stay written even when a stop lands with done
  property p_res_stored;
    @(posedge sys_clk) disable iff (!rstn)
      (s_r.st == ST_WAIT && conv_rsp.done)
      |=> s_r.result[$past(s_r.ch)] == ($past(s_r.sweep_ctl[ASW_BITS_BIT]) ? $past(conv_rsp.data)
                                         : {2'b00, $past(conv_rsp.data[7:0])});
  endproperty
  a_res_stored: assert property (p_res_stored) else $error("result not stored");

  // Late answers of a stopped conversion must not land
  property p_done_ignored;
    @(posedge sys_clk) disable iff (!rstn)
      (conv_rsp.done && s_r.st != ST_WAIT) |=> $stable(s_r.result);
  endproperty
  a_done_ignored: assert property (p_done_ignored) else $error("stray result stored");

endmodule // asw_ctrl
`default_nettype wire

// ===== sim/asw_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module asw_core_model
  import asw_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire asw_pkg::asw_conv_req_t conv_req,
  output var  asw_pkg::asw_conv_rsp_t conv_rsp
);
  // ==========================================================
  // Analog core: answers fast and slow in turn
  logic [3:0] wait_r;
  logic       slow_r;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wait_r   <= 4'h0;
      slow_r   <= 1'b0;
      conv_rsp <= '0;
    end
    else if (conv_req.req)
    begin
      wait_r <= slow_r ? 4'h7 : 4'h1;
      slow_r <= ~slow_r;
    end
    else if (wait_r == 4'h1)
    begin
      wait_r   <= 4'h0;
      conv_rsp <= {1'b1, 5'h1E, conv_req.group, conv_req.channel};
    end
    else
    begin
      // Data not valid outside done: keep it moving
      wait_r        <= (wait_r != 4'h0) ? wait_r - 4'h1 : 4'h0;
      conv_rsp.done <= 1'b0;
      conv_rsp.data <= ~conv_rsp.data;
    end
  end
endmodule // asw_core_model
`default_nettype wire

// ===== sim/test_asw_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module test_asw_ctrl;
  import asw_pkg::*;
  logic          sys_clk = 1'b0;
  logic          rstn = 1'b0;
  logic          ext_trig = 1'b1;
  asw_avs_req_t  avs_req = '0;
  asw_avs_rsp_t  avs_rsp;
  asw_conv_req_t conv_req;
  asw_conv_rsp_t conv_rsp;
  logic          conv_done_irq;
  logic          reference_connect;
  logic [31:0]   rd;
  logic [2:0]    exp_ch = 3'h0;
  logic [1:0]    grp = 2'h0;
  logic          ten = 1'b0;
  int            err_total = 0;
  int            checks_done = 0;
  int            n_req = 0;
  int            n_irq = 0;
  int            last_ch = 1;
  int            n0;
  always #4 sys_clk = ~sys_clk;
  asw_ctrl i_asw_ctrl (.sys_clk(sys_clk), .rstn(rstn), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .external_trigger_input(ext_trig), .conv_req(conv_req), .conv_rsp(conv_rsp),
    .conv_done_irq(conv_done_irq), .reference_connect(reference_connect));
  asw_core_model i_asw_core_model (.sys_clk(sys_clk), .rstn(rstn), .conv_req(conv_req),
    .conv_rsp(conv_rsp));
  // ==========================================================
  // Checking and bus tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task print_verdict;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    avs_req <= {~wr, wr, a, 24'h0, d};
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_rsp.waitrequest !== 1'b0 && n < 50);
    chk("bus answer", 1, n < 50);
    rd = avs_rsp.readdata;
    avs_req <= '0;
  endtask
  task rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(what, exp, rd);
  endtask
  task wait_idle;
    int n;
    n = 0;
    do
    begin
      bus(1'b0, ASW_MODE_OFS, 8'h00);
      n++;
    end
    while (rd[ASW_START_BIT] !== 1'b0 && n < 300);
    chk("sweep end", 1, n < 300);
  endtask
  task start(input logic [7:0] mode, input int last);
    exp_ch = 3'h0;
    last_ch = last;
    n_req = 0;
    n_irq = 0;
    bus(1'b1, ASW_MODE_OFS, mode);
  endtask
  task results(input int last);
    for (int c = 0; c <= last; c++)
      rdchk("result", ASW_RESULT_OFS + 12'(4 * c), ten ? {22'h0, 5'h1E, grp, 3'(c)} : {24'h0, 3'h6, grp, 3'(c)});
  endtask
  // ==========================================================
  // Link monitor: sequence, group and resolution
  always @(posedge sys_clk)
  begin
    if (conv_done_irq === 1'b1)
      n_irq++;
    if (conv_req.req === 1'b1)
    begin
      chk("channel", exp_ch, conv_req.channel);
      chk("group", grp, conv_req.group);
      chk("ten_bit", ten, conv_req.ten_bit);
      n_req++;
      exp_ch = (exp_ch == 3'(last_ch)) ? 3'h0 : exp_ch + 3'h1;
    end
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    rdchk("sweep reset", ASW_SWEEP_OFS, {24'h0, ASW_SWEEP_RST});
    rdchk("mode reset", ASW_MODE_OFS, {24'h0, ASW_MODE_RST});
    rdchk("extra reset", ASW_EXTRA_OFS, {24'h0, ASW_EXTRA_RST});
    rdchk("unmapped", 12'h3F0, 32'h0);
    bus(1'b1, ASW_SWEEP_OFS, 8'h20);
    repeat (ASW_VREF_SETTLE_CYC) @(posedge sys_clk);
    chk("reference", 1, reference_connect);
    // Single sweep, every pin group size, channel field set but unused
    for (int s = 0; s < 4; s++)
    begin
      ten = s[0];
      grp = 2'(s);
      bus(1'b1, ASW_EXTRA_OFS, {5'h0, grp, 1'b0});
      bus(1'b1, ASW_SWEEP_OFS, {4'h2, ten, 1'b0, 2'(s)});
      start(8'h57, 2 * s + 1);
      wait_idle();
      chk("conversions", 2 * s + 2, n_req);
      chk("irq count", 1, n_irq);
      results(2 * s + 1);
    end
    // Repeat sweep 0, four pins, stopped only by clearing the flag
    ten = 1'b1;
    grp = 2'h0;
    bus(1'b1, ASW_EXTRA_OFS, 8'h00);
    bus(1'b1, ASW_SWEEP_OFS, 8'h29);
    start(8'h5D, 3);
    repeat (300) @(posedge sys_clk);
    rdchk("flag running", ASW_MODE_OFS, 32'h5D);
    chk("looping", 1, n_req > 8);
    chk("no irq", 0, n_irq);
    bus(1'b1, ASW_MODE_OFS, 8'h1D);
    repeat (20) @(posedge sys_clk);
    n0 = n_req;
    repeat (60) @(posedge sys_clk);
    chk("stopped", n0, n_req);
    rdchk("flag clear", ASW_MODE_OFS, 32'h1D);
    results(3);
    // Extension bit set with mode 11: one pass, then interrupt
    ten = 1'b0;
    bus(1'b1, ASW_SWEEP_OFS, 8'h24);
    start(8'h58, 1);
    wait_idle();
    chk("one pass", 2, n_req);
    chk("pass irq", 1, n_irq);
    results(1);
    // External trigger: armed, then falling edge
    ten = 1'b0;
    bus(1'b1, ASW_SWEEP_OFS, 8'h20);
    start(8'h70, 1);
    repeat (40) @(posedge sys_clk);
    chk("armed idle", 0, n_req);
    ext_trig <= 1'b0;
    wait_idle();
    chk("triggered", 2, n_req);
    ext_trig <= 1'b1;
    results(1);
    // Reset in mid-run: a running repeat sweep dies, registers return
    ten = 1'b1;
    bus(1'b1, ASW_SWEEP_OFS, 8'h29);
    start(8'h5D, 3);
    repeat (50) @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    rdchk("mode after reset", ASW_MODE_OFS, {24'h0, ASW_MODE_RST});
    rdchk("sweep after reset", ASW_SWEEP_OFS, {24'h0, ASW_SWEEP_RST});
    chk("reference after reset", 0, reference_connect);
    n0 = n_req;
    repeat (40) @(posedge sys_clk);
    chk("idle after reset", n0, n_req);
    print_verdict();
  end
endmodule // test_asw_ctrl
`default_nettype wire
